// ===== verilog/psfr_pkg.sv
// Constants, target indices and state type of the paged register decoder
package psfr_pkg;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int PSFR_NT = 29;
  localparam logic [7:0] PSFR_PAGE_RESET = 8'h00;
  localparam logic [7:0] PSFR_PAGE_ZERO = 8'h00;
  localparam logic [7:0] PSFR_PAGE_F = 8'h0F;

  // ****************************************
  // Direct addresses
  // ****************************************
  localparam logic [7:0] PSFR_A_PAGE = 8'hA7;
  localparam logic [7:0] PSFR_A_ADC = 8'hBA;
  localparam logic [7:0] PSFR_A_REGCF = 8'h96;
  localparam logic [7:0] PSFR_A_REGCN = 8'h97;
  localparam logic [7:0] PSFR_A_PORTA = 8'hA4;
  localparam logic [7:0] PSFR_A_PORTB = 8'hA5;
  localparam logic [7:0] PSFR_A_PORTC = 8'hA6;
  localparam logic [7:0] PSFR_A_XEN1 = 8'hE6;
  localparam logic [7:0] PSFR_A_XEN2 = 8'hE7;
  localparam logic [7:0] PSFR_A_ACC = 8'hE0;
  localparam logic [7:0] PSFR_A_B = 8'hF0;
  localparam logic [7:0] PSFR_A_DPL = 8'h82;
  localparam logic [7:0] PSFR_A_DPH = 8'h83;
  localparam logic [7:0] PSFR_A_LATCHA = 8'h80;
  localparam logic [7:0] PSFR_A_LATCHB = 8'h90;
  localparam logic [7:0] PSFR_A_LATCHC = 8'hA0;
  localparam logic [7:0] PSFR_A_IE = 8'hA8;
  localparam logic [7:0] PSFR_A_CLK = 8'hA9;
  localparam logic [7:0] PSFR_A_CM0 = 8'hDA;
  localparam logic [7:0] PSFR_A_CM1 = 8'hDB;
  localparam logic [7:0] PSFR_A_CM2 = 8'hDC;
  localparam logic [7:0] PSFR_A_CM3 = 8'hDD;
  localparam logic [7:0] PSFR_A_CM4 = 8'hDE;
  localparam logic [7:0] PSFR_A_CM5 = 8'hCE;
  localparam logic [2:0] PSFR_BIT_LOW = 3'h0;

  // ****************************************
  // Target indices on the select vector
  // ****************************************
  localparam logic [4:0] PSFR_T_ADC_ACC = 5'h00;
  localparam logic [4:0] PSFR_T_ADC_PWR = 5'h01;
  localparam logic [4:0] PSFR_T_REG_CF = 5'h02;
  localparam logic [4:0] PSFR_T_REG_CN = 5'h03;
  localparam logic [4:0] PSFR_T_CRC_AUTO = 5'h04;
  localparam logic [4:0] PSFR_T_CRC_CNT = 5'h05;
  localparam logic [4:0] PSFR_T_PA_MODE = 5'h06;
  localparam logic [4:0] PSFR_T_PA_DRV = 5'h09;
  localparam logic [4:0] PSFR_T_XEN1 = 5'h0C;
  localparam logic [4:0] PSFR_T_XEN2 = 5'h0D;
  localparam logic [4:0] PSFR_T_ACC = 5'h0E;
  localparam logic [4:0] PSFR_T_B = 5'h0F;
  localparam logic [4:0] PSFR_T_DPL = 5'h10;
  localparam logic [4:0] PSFR_T_DPH = 5'h11;
  localparam logic [4:0] PSFR_T_LATCHA = 5'h12;
  localparam logic [4:0] PSFR_T_LATCHB = 5'h13;
  localparam logic [4:0] PSFR_T_LATCHC = 5'h14;
  localparam logic [4:0] PSFR_T_IE = 5'h15;
  localparam logic [4:0] PSFR_T_CLK = 5'h16;
  localparam logic [4:0] PSFR_T_CM0 = 5'h17;
  localparam logic [4:0] PSFR_T_CM5 = 5'h1C;

  // ****************************************
  // State of the decoder
  // ****************************************
  typedef struct packed {
    logic [7:0] page;
    logic [PSFR_NT-1:0] sel;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic refused;
  } psfr_state_t;

endpackage

// ===== verilog/psfr_map.sv
// Address and page to target lookup
`timescale 1ns/100ps
module psfr_map (
  // Access
  input wire logic [7:0] addr,
  input wire logic [7:0] page,
  // Result
  output logic hit,
  output logic page_hit,
  output logic bit_ok,
  output logic [4:0] tidx
);
  import psfr_pkg::*;

  logic p0;
  logic pf;

  always_comb begin
    p0 = (page == PSFR_PAGE_ZERO);
    pf = (page == PSFR_PAGE_F);
    hit = 1'b0;
    page_hit = 1'b0;
    tidx = 5'h00;
    bit_ok = (addr[2:0] == PSFR_BIT_LOW);
    unique case (addr)
      PSFR_A_PAGE: page_hit = 1'b1;
      PSFR_A_ADC: begin
        hit = p0 | pf;
        tidx = pf ? PSFR_T_ADC_PWR : PSFR_T_ADC_ACC;
      end
      PSFR_A_REGCF: begin
        hit = p0 | pf;
        tidx = pf ? PSFR_T_CRC_AUTO : PSFR_T_REG_CF;
      end
      PSFR_A_REGCN: begin
        hit = p0 | pf;
        tidx = pf ? PSFR_T_CRC_CNT : PSFR_T_REG_CN;
      end
      PSFR_A_PORTA, PSFR_A_PORTB, PSFR_A_PORTC: begin
        hit = p0 | pf;
        tidx = (pf ? PSFR_T_PA_DRV : PSFR_T_PA_MODE) + {3'h0, addr[1:0]};
      end
      PSFR_A_XEN1: begin
        hit = 1'b1;
        tidx = PSFR_T_XEN1;
      end
      PSFR_A_XEN2: begin
        hit = 1'b1;
        tidx = PSFR_T_XEN2;
      end
      PSFR_A_ACC: begin
        hit = 1'b1;
        tidx = PSFR_T_ACC;
      end
      PSFR_A_B: begin
        hit = 1'b1;
        tidx = PSFR_T_B;
      end
      PSFR_A_DPL: begin
        hit = 1'b1;
        tidx = PSFR_T_DPL;
      end
      PSFR_A_DPH: begin
        hit = 1'b1;
        tidx = PSFR_T_DPH;
      end
      PSFR_A_LATCHA: begin
        hit = 1'b1;
        tidx = PSFR_T_LATCHA;
      end
      PSFR_A_LATCHB: begin
        hit = 1'b1;
        tidx = PSFR_T_LATCHB;
      end
      PSFR_A_LATCHC: begin
        hit = 1'b1;
        tidx = PSFR_T_LATCHC;
      end
      PSFR_A_IE: begin
        hit = 1'b1;
        tidx = PSFR_T_IE;
      end
      PSFR_A_CLK: begin
        hit = 1'b1;
        tidx = PSFR_T_CLK;
      end
      PSFR_A_CM0, PSFR_A_CM1, PSFR_A_CM2, PSFR_A_CM3, PSFR_A_CM4: begin
        hit = p0;
        tidx = PSFR_T_CM0 + 5'(addr - PSFR_A_CM0);
      end
      PSFR_A_CM5: begin
        hit = p0;
        tidx = PSFR_T_CM5;
      end
      default: hit = 1'b0;
    endcase
  end

endmodule

// ===== verilog/psfr_decoder.sv
// Paged special function register decoder, top level
`timescale 1ns/100ps
module psfr_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core access
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_bit,
  input wire logic [2:0] cpu_bit_pos,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_refused,
  // Peripheral targets
  input wire logic [psfr_pkg::PSFR_NT*8-1:0] tgt_rdata,
  output logic [psfr_pkg::PSFR_NT-1:0] tgt_sel,
  output logic tgt_wr,
  output logic [7:0] tgt_wdata,
  output logic [7:0] sfr_page_select
);
  import psfr_pkg::*;

  // ****************************************
  // Lookup
  // ****************************************
  psfr_state_t st;
  psfr_state_t next_st;
  logic hit;
  logic page_hit;
  logic bit_ok;
  logic [4:0] tidx;
  logic [7:0] cur;
  logic [7:0] byte_val;
  logic [7:0] wval;

  psfr_map u_map (
    .addr(cpu_addr),
    .page(st.page),
    .hit(hit),
    .page_hit(page_hit),
    .bit_ok(bit_ok),
    .tidx(tidx)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cur = tgt_rdata[{tidx, 3'h0} +: 8];
    byte_val = page_hit ? st.page : (hit ? cur : 8'h00);
    wval = cpu_bit ? byte_val : cpu_wdata;
    if (cpu_bit) begin
      wval[cpu_bit_pos] = cpu_wdata[0];
    end
    next_st = st;
    next_st.sel = '0;
    next_st.wr = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.refused = 1'b0;
    if (cpu_wr || cpu_rd) begin
      if (cpu_bit && !bit_ok) begin
        next_st.refused = 1'b1;
        next_st.rvalid = cpu_rd & ~cpu_wr;
        next_st.rdata = 8'h00;
      end else if (cpu_wr) begin
        if (page_hit) begin
          next_st.page = wval;
        end else if (hit) begin
          next_st.sel[tidx] = 1'b1;
          next_st.wr = 1'b1;
          next_st.wdata = wval;
        end
      end else begin
        next_st.rvalid = 1'b1;
        next_st.rdata = cpu_bit ? {7'h00, byte_val[cpu_bit_pos]} : byte_val;
        if (hit) begin
          next_st.sel[tidx] = 1'b1;
        end
      end
    end
    if (srst) begin
      next_st = '0;
      next_st.page = PSFR_PAGE_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign cpu_rdata = st.rdata;
  assign cpu_rvalid = st.rvalid;
  assign cpu_refused = st.refused;
  assign tgt_sel = st.sel;
  assign tgt_wr = st.wr;
  assign tgt_wdata = st.wdata;
  assign sfr_page_select = st.page;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic wr_byte;
  assign wr_byte = cpu_wr && !cpu_bit;

  page_reset_a: assert property (disable iff (1'b0) srst |=> sfr_page_select == 8'h00)
    else $error("page not zero after reset");
  page_write_a: assert property (wr_byte && cpu_addr == 8'hA7 |=>
    sfr_page_select == $past(cpu_wdata) && tgt_sel == '0)
    else $error("page write lost");
  page_read_a: assert property (cpu_rd && !cpu_wr && !cpu_bit && cpu_addr == 8'hA7 |=>
    cpu_rvalid && cpu_rdata == $past(sfr_page_select))
    else $error("page read wrong");
  adc_alias_a: assert property (wr_byte && cpu_addr == 8'hBA && sfr_page_select == 8'h0F |=>
    tgt_wr && tgt_sel[PSFR_T_ADC_PWR] && !tgt_sel[PSFR_T_ADC_ACC])
    else $error("burst power-up alias wrong");
  adc_page0_a: assert property (wr_byte && cpu_addr == 8'hBA && sfr_page_select == 8'h00 |=>
    tgt_sel[PSFR_T_ADC_ACC])
    else $error("accumulator alias wrong");
  crc_alias_a: assert property (wr_byte && cpu_addr == 8'h96 && sfr_page_select == 8'h0F |=>
    tgt_sel[PSFR_T_CRC_AUTO])
    else $error("crc auto alias wrong");
  reg_ctrl_a: assert property (wr_byte && cpu_addr == 8'h97 && sfr_page_select == 8'h00 |=>
    tgt_sel[PSFR_T_REG_CN])
    else $error("regulator control alias wrong");
  port_mode_a: assert property (wr_byte && cpu_addr == 8'hA6 && sfr_page_select == 8'h00 |=>
    tgt_sel[PSFR_T_PA_MODE + 5'h02])
    else $error("port mode alias wrong");
  port_drive_a: assert property (wr_byte && cpu_addr == 8'hA4 && sfr_page_select == 8'h0F |=>
    tgt_sel[PSFR_T_PA_DRV] && tgt_wdata == $past(cpu_wdata))
    else $error("drive strength alias wrong");
  common_page_a: assert property ((cpu_wr || cpu_rd) && !cpu_bit && cpu_addr == 8'hE7 |=>
    tgt_sel[PSFR_T_XEN2])
    else $error("common register missed");
  counter_page_a: assert property (wr_byte && cpu_addr == 8'hCE && sfr_page_select != 8'h00 |=>
    !tgt_wr && tgt_sel == '0)
    else $error("counter mode off page 0x0");
  full_page_a: assert property (wr_byte && cpu_addr == 8'hBA && sfr_page_select[7:4] != 4'h0 |=>
    tgt_sel == '0)
    else $error("upper page bits ignored");
  bit_refuse_a: assert property (cpu_wr && cpu_bit && cpu_addr[2:0] != 3'h0 |=>
    cpu_refused && !tgt_wr && tgt_sel == '0)
    else $error("bit access not refused");
  unmapped_a: assert property (cpu_rd && !cpu_wr && cpu_addr == 8'hB4 |=>
    cpu_rvalid && cpu_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ****************************************
  // Alias, bit access, select and page hold checks
  // ****************************************
  refuse_pulse_a: assert property (
    cpu_refused |-> $past((cpu_wr || cpu_rd) && cpu_bit && cpu_addr[2:0] != 3'h0))
    else $error("refusal without bit access");
  refused_read_a: assert property (
    cpu_rd && !cpu_wr && cpu_bit && cpu_addr[2:0] != 3'h0 |=>
    cpu_rvalid && cpu_refused && cpu_rdata == 8'h00 && tgt_sel == '0)
    else $error("refused read wrong");
  bit_write_a: assert property (
    cpu_wr && cpu_bit && cpu_addr == 8'h80 |=> tgt_wr && tgt_sel[PSFR_T_LATCHA] &&
    tgt_wdata[$past(cpu_bit_pos)] == $past(cpu_wdata[0]))
    else $error("bit write not merged");
  bit_read_a: assert property (
    cpu_rd && !cpu_wr && cpu_bit && cpu_addr == 8'hA8 |=> cpu_rvalid &&
    cpu_rdata == {7'h00, $past(tgt_rdata[{PSFR_T_IE, 3'h0} + 8'(cpu_bit_pos)])})
    else $error("bit read wrong");
  adc_data_a: assert property (
    wr_byte && cpu_addr == 8'hBA && sfr_page_select == 8'h00 |=>
    tgt_wr && tgt_wdata == $past(cpu_wdata))
    else $error("accumulator write data lost");
  reg_cfg_a: assert property (
    wr_byte && cpu_addr == 8'h96 && sfr_page_select == 8'h00 |=>
    tgt_wr && tgt_sel[PSFR_T_REG_CF])
    else $error("regulator setup alias wrong");
  crc_count_a: assert property (
    wr_byte && cpu_addr == 8'h97 && sfr_page_select == 8'h0F |=>
    tgt_wr && tgt_sel[PSFR_T_CRC_CNT])
    else $error("crc sector count alias wrong");
  port_mode_b_a: assert property (
    wr_byte && cpu_addr == 8'hA5 && sfr_page_select == 8'h00 |=>
    tgt_wr && tgt_sel[PSFR_T_PA_MODE + 5'h01])
    else $error("second port mode alias wrong");
  port_drive_c_a: assert property (
    wr_byte && cpu_addr == 8'hA6 && sfr_page_select == 8'h0F |=>
    tgt_wr && tgt_sel[PSFR_T_PA_DRV + 5'h02])
    else $error("third drive strength alias wrong");
  read_common_a: assert property (
    cpu_rd && !cpu_wr && !cpu_bit && cpu_addr == 8'hE6 |=> cpu_rvalid &&
    tgt_sel[PSFR_T_XEN1] && cpu_rdata == $past(tgt_rdata[{PSFR_T_XEN1, 3'h0} +: 8]))
    else $error("common register read wrong");
  counter_mid_a: assert property (
    wr_byte && cpu_addr == 8'hDC && sfr_page_select == 8'h00 |=>
    tgt_wr && tgt_sel[PSFR_T_CM0 + 5'h02])
    else $error("counter mode alias wrong");
  counter_last_a: assert property (
    wr_byte && cpu_addr == 8'hCE && sfr_page_select == 8'h00 |=>
    tgt_wr && tgt_sel[PSFR_T_CM5])
    else $error("last counter mode missed");
  sel_onehot_a: assert property (
    cpu_wr || cpu_rd |=> $onehot0(tgt_sel))
    else $error("more than one target selected");
  page_hold_a: assert property (
    !(cpu_wr && !cpu_bit && cpu_addr == 8'hA7) |=> $stable(sfr_page_select))
    else $error("page changed without a write");
  unmapped_wr_a: assert property (
    wr_byte && cpu_addr == 8'hB4 |=> !tgt_wr && tgt_sel == '0)
    else $error("unmapped write reached a target");

  page_f_c: cover property (wr_byte && cpu_addr == 8'hA7 && cpu_wdata == 8'h0F);
  alias_c: cover property (tgt_wr && tgt_sel[PSFR_T_CRC_CNT]);
  bit_wr_c: cover property (cpu_wr && cpu_bit && cpu_addr == 8'hA0);
  refused_c: cover property (cpu_refused && cpu_rvalid);
  page_back_c: cover property (wr_byte && cpu_addr == 8'hA7 && cpu_wdata == 8'h00 &&
    sfr_page_select == 8'h0F);

endmodule

// ===== tb/psfr_target_model.sv
// Behavioural register files of the peripherals behind the decoder
`timescale 1ns/100ps
module psfr_target_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoder side
  input wire logic [psfr_pkg::PSFR_NT-1:0] tgt_sel,
  input wire logic tgt_wr,
  input wire logic [7:0] tgt_wdata,
  output logic [psfr_pkg::PSFR_NT*8-1:0] tgt_rdata
);
  import psfr_pkg::*;

  logic [7:0] regs [PSFR_NT];

  // Each target takes the byte when selected with the write strobe
  always_ff @(posedge clk) begin
    for (int i = 0; i < PSFR_NT; i++) begin
      if (srst) begin
        regs[i] <= 8'h00;
      end else if (tgt_sel[i] && tgt_wr) begin
        regs[i] <= tgt_wdata;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PSFR_NT; i++) begin
      tgt_rdata[i*8 +: 8] = regs[i];
    end
  end
endmodule

// ===== tb/psfr_decoder_bench.sv
// Self-checking bench of the paged register decoder
`timescale 1ns/100ps
module psfr_decoder_bench;
  import psfr_pkg::*;
  logic clk, srst, cpu_wr, cpu_rd, cpu_bit, tgt_wr, cpu_rvalid, cpu_refused;
  logic [2:0] cpu_bit_pos;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, tgt_wdata, sfr_page_select, pg;
  logic [PSFR_NT*8-1:0] tgt_rdata;
  logic [PSFR_NT-1:0] tgt_sel;
  logic [7:0] mirror [PSFR_NT];
  int miscompares = 0;
  int compares = 0;
  logic [7:0] a0 [12] = '{8'hBA, 8'h96, 8'h97, 8'hA4, 8'hA5, 8'hA6,
                          8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hCE};
  int i0 [12] = '{0, 2, 3, 6, 7, 8, 23, 24, 25, 26, 27, 28};
  logic [7:0] af [6] = '{8'hBA, 8'h96, 8'h97, 8'hA4, 8'hA5, 8'hA6};
  int i_f [6] = '{1, 4, 5, 9, 10, 11};
  logic [7:0] aa [11] = '{8'hE6, 8'hE7, 8'hE0, 8'hF0, 8'h82, 8'h83,
                          8'h80, 8'h90, 8'hA0, 8'hA8, 8'hA9};

  psfr_decoder psfr_decoder_inst (.clk(clk), .srst(srst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_bit(cpu_bit), .cpu_bit_pos(cpu_bit_pos),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .cpu_refused(cpu_refused), .tgt_rdata(tgt_rdata), .tgt_sel(tgt_sel),
    .tgt_wr(tgt_wr), .tgt_wdata(tgt_wdata), .sfr_page_select(sfr_page_select));
  psfr_target_model psfr_target_model_inst (.clk(clk), .srst(srst), .tgt_sel(tgt_sel),
    .tgt_wr(tgt_wr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d, errors %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    pg = 8'h00;
    foreach (mirror[i]) mirror[i] = 8'h00;
  endtask

  // One access: drive at a falling edge, answer checked one cycle later
  task automatic acc(input logic rd, input logic bt, input logic [2:0] bp,
                     input logic [7:0] a, input logic [7:0] d, input int idx, input logic rf);
    logic [7:0] e;
    logic [31:0] s;
    e = 8'h00;
    s = 32'h0;
    if (idx >= 0) s[idx] = 1'b1;
    if (rd && a == 8'hA7) e = pg;
    else if (rd && idx >= 0) e = bt ? {7'h00, mirror[idx][bp]} : mirror[idx];
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bit = bt;
    cpu_bit_pos = bp;
    cpu_rd = rd;
    cpu_wr = !rd;
    @(negedge clk);
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    if (!rd && idx >= 0) begin
      if (bt) mirror[idx][bp] = d[0];
      else mirror[idx] = d;
    end
    if (!rd && !bt && a == 8'hA7) pg = d;
    cmp({3'h0, tgt_sel}, s, "target select");
    cmp(tgt_wr, !rd && idx >= 0, "write strobe");
    cmp(cpu_refused, rf, "refusal");
    cmp(cpu_rvalid, rd, "read valid");
    cmp(sfr_page_select, pg, "page register");
    if (rd) cmp(cpu_rdata, e, "read data");
    if (!rd && idx >= 0) cmp(tgt_wdata, mirror[idx], "write data");
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1000000;
    miscompares++;
    summarize();
  end

  initial begin
    {srst, cpu_wr, cpu_rd, cpu_bit, cpu_bit_pos, cpu_addr, cpu_wdata} = '0;
    do_reset();
    cmp(sfr_page_select, 8'h00, "page after reset");
    acc(1, 0, 0, 8'hA7, 0, -1, 0);
    for (int i = 0; i < 12; i++) begin
      acc(0, 0, 0, a0[i], 8'(8'h30 + i), i0[i], 0);
      acc(1, 0, 0, a0[i], 0, i0[i], 0);
    end
    foreach (aa[i]) acc(0, 0, 0, aa[i], 8'(8'h50 + i), 12 + i, 0);
    acc(0, 0, 0, 8'hA8, 8'h85, 21, 0);
    acc(1, 0, 0, 8'hA8, 0, 21, 0);
    acc(0, 0, 0, 8'hA8, 8'h05, 21, 0);
    acc(0, 0, 0, 8'hA7, 8'h0F, -1, 0);
    foreach (af[i]) begin
      acc(0, 0, 0, af[i], 8'(8'hC0 + i), i_f[i], 0);
      acc(1, 0, 0, af[i], 0, i_f[i], 0);
    end
    for (int i = 6; i < 12; i++) begin
      acc(0, 0, 0, a0[i], 8'hEE, -1, 0);
      acc(1, 0, 0, a0[i], 0, -1, 0);
    end
    foreach (aa[i]) acc(1, 0, 0, aa[i], 0, 12 + i, 0);
    acc(0, 0, 0, 8'hA7, 8'h00, -1, 0);
    acc(0, 0, 0, 8'hA8, 8'h85, 21, 0);
    acc(0, 0, 0, 8'hA7, 8'h1F, -1, 0);
    acc(1, 0, 0, 8'hA7, 0, -1, 0);
    foreach (af[i]) begin
      acc(0, 0, 0, af[i], 8'hAA, -1, 0);
      acc(1, 0, 0, af[i], 0, -1, 0);
    end
    acc(1, 0, 0, 8'hE6, 0, 12, 0);
    acc(0, 0, 0, 8'hA7, 8'h00, -1, 0);
    acc(0, 1, 3, 8'h80, 8'h01, 18, 0);
    acc(1, 1, 3, 8'h80, 0, 18, 0);
    acc(1, 1, 7, 8'hA8, 0, 21, 0);
    acc(0, 1, 2, 8'hA4, 8'h01, -1, 1);
    acc(1, 0, 0, 8'hA4, 0, 6, 0);
    acc(1, 1, 2, 8'hA4, 0, -1, 1);
    acc(0, 0, 0, 8'hB4, 8'h77, -1, 0);
    acc(1, 0, 0, 8'hB4, 0, -1, 0);
    acc(0, 0, 0, 8'hA7, 8'h0F, -1, 0);
    do_reset();
    cmp(sfr_page_select, 8'h00, "page after second reset");
    acc(1, 0, 0, 8'hBA, 0, 0, 0);
    summarize();
  end
endmodule
